// ===== design/mcuit_consts.svh
`ifndef MCUIT_CONSTS_SVH
`define MCUIT_CONSTS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define MCUIT_CLK_PER_CYCLE 4
`define MCUIT_PHASE_LAST    2'h3

// ----------------------------------------------------------------
// Instruction word fields
// ----------------------------------------------------------------
`define MCUIT_OP_HI  15
`define MCUIT_OP_LO  11
`define MCUIT_BIT_HI 10
`define MCUIT_BIT_LO 8
`define MCUIT_TGT_HI 10

// ----------------------------------------------------------------
// Data space map and reset values
// ----------------------------------------------------------------
`define MCUIT_ADDR_PCL      8'h06
`define MCUIT_ADDR_TBLH     8'h08
`define MCUIT_ADDR_STATUS   8'h0A
`define MCUIT_ADDR_PORT_OUT 8'h12
`define MCUIT_ADDR_PORT_IN  8'h13
`define MCUIT_STATUS_C      0
`define MCUIT_STATUS_Z      1
`define MCUIT_STATUS_IE     2
`define MCUIT_RST_PC        11'h000
`define MCUIT_INT_VECTOR    11'h004
`define MCUIT_TBL_PAGE      3'h7
`define MCUIT_BYTE_MAX      9'h0FF

`endif

// ===== design/mcuit_pkg.sv
package mcuit_pkg;

  typedef logic [10:0] mcuit_addr_t;
  typedef logic [7:0]  mcuit_byte_t;
  typedef logic [15:0] mcuit_word_t;

  // Thirty-two operations fill the five-bit opcode field exactly
  typedef enum logic [4:0] {
    OP_NOP, OP_MOV_A_M, OP_MOV_M_A, OP_MOV_A_X,
    OP_ADD_A_M, OP_ADD_A_X, OP_SUB_A_M, OP_AND_A_M,
    OP_OR_A_M, OP_XOR_A_M, OP_CPL_M, OP_CPLA_M,
    OP_INC_M, OP_INCREMENT_TO_ACC_M, OP_DEC_M, OP_DECREMENT_TO_ACC_M,
    OP_RR_M, OP_RL_M, OP_RRC_M, OP_RLC_M,
    OP_SET_BIT, OP_CLR_BIT, OP_SZ_M, OP_SZ_BIT,
    OP_SNZ_BIT, OP_JUMP, OP_CALL, OP_RET,
    OP_INTERRUPT_EXIT, OP_TABRD, OP_HALT, OP_CLRWDT
  } mcuit_op_e;

  typedef struct packed {
    mcuit_byte_t res;
    logic        c;
    logic        z;
    logic        wr_acc;
    logic        wr_mem;
    logic        set_c;
    logic        set_z;
    logic        skip;
  } mcuit_alu_s;

endpackage : mcuit_pkg

// ===== design/mcuit_alu.sv
`timescale 1ns/10ps
`default_nettype none
`include "mcuit_consts.svh"

module mcuit_alu (
  input  wire mcuit_pkg::mcuit_op_e   op,
  input  wire mcuit_pkg::mcuit_byte_t acc,
  input  wire mcuit_pkg::mcuit_byte_t mem,
  input  wire mcuit_pkg::mcuit_byte_t imm,
  input  wire logic [2:0]             bit_sel,
  input  wire logic                   cin,
  output var mcuit_pkg::mcuit_alu_s   alu_o
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic mcuit_pkg::mcuit_byte_t bit_mask(input logic [2:0] idx);
    bit_mask = 8'h01 << idx;
  endfunction : bit_mask

  logic [8:0] sum9;

  // ----------------------------------------------------------------
  // Datapath: results go to the accumulator or back to the location; skip tests write neither
  // ----------------------------------------------------------------
  always_comb begin
    sum9  = 9'h000;
    alu_o = '0;
    case (op)
      mcuit_pkg::OP_MOV_A_M: begin alu_o.res = mem; alu_o.wr_acc = 1'b1; end
      mcuit_pkg::OP_MOV_M_A: begin alu_o.res = acc; alu_o.wr_mem = 1'b1; end
      mcuit_pkg::OP_MOV_A_X: begin alu_o.res = imm; alu_o.wr_acc = 1'b1; end
      // [RL9] carry and borrow
      mcuit_pkg::OP_ADD_A_M, mcuit_pkg::OP_ADD_A_X: begin
        sum9 = {1'b0, acc} + {1'b0, (op == mcuit_pkg::OP_ADD_A_X) ? imm : mem};
        alu_o.res = sum9[7:0];
        alu_o.c = sum9 > `MCUIT_BYTE_MAX;
        {alu_o.wr_acc, alu_o.set_c, alu_o.set_z} = 3'h7;
      end
      mcuit_pkg::OP_SUB_A_M: begin
        sum9 = {1'b0, acc} - {1'b0, mem};
        alu_o.res = sum9[7:0];
        alu_o.c = sum9[8];                 // Set on borrow
        {alu_o.wr_acc, alu_o.set_c, alu_o.set_z} = 3'h7;
      end
      // [RL11] logic sets zero
      mcuit_pkg::OP_AND_A_M: begin alu_o.res = acc & mem; {alu_o.wr_acc, alu_o.set_z} = 2'h3; end
      mcuit_pkg::OP_OR_A_M:  begin alu_o.res = acc | mem; {alu_o.wr_acc, alu_o.set_z} = 2'h3; end
      mcuit_pkg::OP_XOR_A_M: begin alu_o.res = acc ^ mem; {alu_o.wr_acc, alu_o.set_z} = 2'h3; end
      mcuit_pkg::OP_CPL_M:   begin alu_o.res = ~mem; {alu_o.wr_mem, alu_o.set_z} = 2'h3; end
      mcuit_pkg::OP_CPLA_M:  begin alu_o.res = ~mem; {alu_o.wr_acc, alu_o.set_z} = 2'h3; end
      // [RL10] step by one
      mcuit_pkg::OP_INC_M:   begin alu_o.res = mem + 8'h01; {alu_o.wr_mem, alu_o.set_z} = 2'h3; end
      mcuit_pkg::OP_INCREMENT_TO_ACC_M:  begin alu_o.res = mem + 8'h01; {alu_o.wr_acc, alu_o.set_z} = 2'h3; end
      mcuit_pkg::OP_DEC_M:   begin alu_o.res = mem - 8'h01; {alu_o.wr_mem, alu_o.set_z} = 2'h3; end
      mcuit_pkg::OP_DECREMENT_TO_ACC_M:  begin alu_o.res = mem - 8'h01; {alu_o.wr_acc, alu_o.set_z} = 2'h3; end
      // [RL13] one-bit rotates
      mcuit_pkg::OP_RR_M:  begin alu_o.res = {mem[0], mem[7:1]}; alu_o.wr_mem = 1'b1; end
      mcuit_pkg::OP_RL_M:  begin alu_o.res = {mem[6:0], mem[7]}; alu_o.wr_mem = 1'b1; end
      mcuit_pkg::OP_RRC_M: begin
        alu_o.res = {cin, mem[7:1]};
        alu_o.c = mem[0];
        {alu_o.wr_mem, alu_o.set_c} = 2'h3;
      end
      mcuit_pkg::OP_RLC_M: begin
        alu_o.res = {mem[6:0], cin};
        alu_o.c = mem[7];
        {alu_o.wr_mem, alu_o.set_c} = 2'h3;
      end
      // [RL14] single bit modify
      mcuit_pkg::OP_SET_BIT: begin alu_o.res = mem | bit_mask(bit_sel); alu_o.wr_mem = 1'b1; end
      mcuit_pkg::OP_CLR_BIT: begin alu_o.res = mem & ~bit_mask(bit_sel); alu_o.wr_mem = 1'b1; end
      // [RL6] skip conditions
      mcuit_pkg::OP_SZ_M:    alu_o.skip = mem == 8'h00;
      mcuit_pkg::OP_SZ_BIT:  alu_o.skip = (mem & bit_mask(bit_sel)) == 8'h00;
      mcuit_pkg::OP_SNZ_BIT: alu_o.skip = (mem & bit_mask(bit_sel)) != 8'h00;
      default: ;                           // Flow ops handled by the sequencer
    endcase
    alu_o.z = alu_o.res == 8'h00;
  end

endmodule : mcuit_alu
`default_nettype wire

// ===== design/mcuit_core.sv
`timescale 1ns/10ps
`default_nettype none
`include "mcuit_consts.svh"

// How it works
// [RL1] Four clocks make one instruction cycle; all timing counts those cycles.
// [RL2] Ordinary instructions finish in one instruction cycle.
// [RL3] Jump, call, return, interrupt return and table read take two cycles.
// [RL4] Writing the low program counter byte jumps there, one extra cycle.
// [RL5] Skip tests cost one cycle, or two when the skip is taken.
// [RL6] Skip tests look at a location or bit, then skip or not.
// [RL7] Jump saves nothing; return resumes just after the call.
// [RL8] Moves: location to accumulator, accumulator to location, constant to accumulator.
// [RL9] Add and subtract flag carry above 255 and borrow below zero.
// [RL10] Increment and decrement step by one, to location or accumulator.
// [RL11] AND, OR, XOR and complement set zero flag on zero result.
// [RL12] Operations pass one operand through the accumulator.
// [RL13] Rotates move one bit; carry forms shift the lost bit into carry.
// [RL14] Bit set and clear rewrite the byte, changing only that bit.
// [RL15] Table read fetches program memory words into data registers.
// [RL16] One instruction powers down; another clears the watchdog.
// [RL17] Call and interrupt entry push only the program counter.
// [RL18] Two-cycle flow drops the prefetched word and fetches the target.
module mcuit_core #(
  parameter int STACK_DEPTH = 4,
  parameter int RAM_DEPTH   = 256
) (
  input  wire logic                   CLK,
  input  wire logic                   RST,
  output var mcuit_pkg::mcuit_addr_t  PROG_ADDR,
  input  wire mcuit_pkg::mcuit_word_t PROG_DATA,
  input  wire logic [7:0]             PORT_IN,
  output logic [7:0]                  PORT_OUT,
  input  wire logic                   INT_REQ,
  input  wire logic                   WAKE,
  output logic                        POWER_DOWN,
  output logic                        WDT_CLEAR,
  output logic                        EXEC_DONE
);

  localparam int SP_W = $clog2(STACK_DEPTH);
  localparam logic [SP_W-1:0] SP_ONE = SP_W'(1);

  logic [1:0]             phase_ff, nxt_phase;
  logic                   ex_stb, exec_now, irq_take;
  logic [7:0]             pin_s1_ff, pin_s2_ff;
  logic [1:0]             ctl_s1_ff, ctl_s2_ff;
  mcuit_pkg::mcuit_addr_t prog_addr_ff, nxt_prog_addr, ir_pc_ff, nxt_ir_pc;
  mcuit_pkg::mcuit_word_t ir_ff, nxt_ir;
  logic                   ir_valid_ff, nxt_ir_valid;
  mcuit_pkg::mcuit_byte_t acc_ff, nxt_acc, tblh_ff, nxt_tblh, port_out_ff, nxt_port_out;
  logic                   c_ff, nxt_c, z_ff, nxt_z, ie_ff, nxt_ie;
  logic                   tbl_pend_ff, nxt_tbl_pend, pd_ff, nxt_pd;
  mcuit_pkg::mcuit_byte_t tbl_dst_ff, nxt_tbl_dst;
  logic                   wdt_ff, nxt_wdt, done_ff, nxt_done;
  logic [SP_W-1:0]        sp_ff, nxt_sp;
  mcuit_pkg::mcuit_addr_t stk_ff [STACK_DEPTH];
  mcuit_pkg::mcuit_byte_t ram_ff [RAM_DEPTH];
  logic                   stk_we, ram_we;
  mcuit_pkg::mcuit_addr_t stk_wd;
  mcuit_pkg::mcuit_byte_t ram_wa, ram_wd, m_rd;
  mcuit_pkg::mcuit_op_e   op;
  mcuit_pkg::mcuit_byte_t m_addr, imm;
  logic [2:0]             bit_sel;
  mcuit_pkg::mcuit_addr_t target;
  mcuit_pkg::mcuit_alu_s  alu_o;
  logic [8:0]             add_sum9;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Pins are asynchronous to CLK; only the second stage is read
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pin_s1_ff <= 8'h00;
      pin_s2_ff <= 8'h00;
      ctl_s1_ff <= 2'h0;
      ctl_s2_ff <= 2'h0;
    end else begin
      pin_s1_ff <= PORT_IN;
      pin_s2_ff <= pin_s1_ff;
      ctl_s1_ff <= {WAKE, INT_REQ};
      ctl_s2_ff <= ctl_s1_ff;
    end
  end

  // ----------------------------------------------------------------
  // Instruction cycle phase
  // ----------------------------------------------------------------
  // [RL1] four clock phases
  always_comb begin
    nxt_phase = phase_ff + 2'h1;
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      phase_ff <= 2'h0;
    end else begin
      phase_ff <= nxt_phase;
    end
  end

  // Everything architectural except the power-down exit changes only on the last phase
  assign ex_stb = phase_ff == `MCUIT_PHASE_LAST;

  // ----------------------------------------------------------------
  // Decode and operand fetch
  // ----------------------------------------------------------------
  assign op       = mcuit_pkg::mcuit_op_e'(ir_ff[`MCUIT_OP_HI:`MCUIT_OP_LO]);
  assign m_addr   = ir_ff[7:0];
  assign imm      = ir_ff[7:0];
  assign bit_sel  = ir_ff[`MCUIT_BIT_HI:`MCUIT_BIT_LO];
  assign target   = ir_ff[`MCUIT_TGT_HI:0];
  assign irq_take = ctl_s2_ff[0] && ie_ff;
  assign exec_now = ex_stb && !pd_ff && !tbl_pend_ff && ir_valid_ff && !irq_take;
  assign add_sum9 = {1'b0, acc_ff} + {1'b0, (op == mcuit_pkg::OP_ADD_A_X) ? imm : m_rd};

  // Special registers overlay the plain data array
  always_comb begin
    m_rd = 8'h00;
    case (m_addr)
      `MCUIT_ADDR_PCL:      m_rd = ir_pc_ff[7:0];
      `MCUIT_ADDR_TBLH:     m_rd = tblh_ff;
      `MCUIT_ADDR_PORT_IN:  m_rd = pin_s2_ff;
      `MCUIT_ADDR_PORT_OUT: m_rd = port_out_ff;
      `MCUIT_ADDR_STATUS: begin
        m_rd[`MCUIT_STATUS_C]  = c_ff;
        m_rd[`MCUIT_STATUS_Z]  = z_ff;
        m_rd[`MCUIT_STATUS_IE] = ie_ff;
      end
      default:              m_rd = ram_ff[m_addr];
    endcase
  end

  // [RL12] accumulator-centred datapath
  mcuit_alu u_alu (
    .op      (op),
    .acc     (acc_ff),
    .mem     (m_rd),
    .imm     (imm),
    .bit_sel (bit_sel),
    .cin     (c_ff),
    .alu_o   (alu_o)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    nxt_prog_addr = prog_addr_ff;
    nxt_ir        = ir_ff;
    nxt_ir_pc     = ir_pc_ff;
    nxt_ir_valid  = ir_valid_ff;
    nxt_acc       = acc_ff;
    nxt_c         = c_ff;
    nxt_z         = z_ff;
    nxt_ie        = ie_ff;
    nxt_tblh      = tblh_ff;
    nxt_tbl_pend  = tbl_pend_ff;
    nxt_tbl_dst   = tbl_dst_ff;
    nxt_sp        = sp_ff;
    nxt_pd        = pd_ff;
    nxt_port_out  = port_out_ff;
    nxt_wdt       = 1'b0;
    nxt_done      = 1'b0;
    stk_we        = 1'b0;
    stk_wd        = ir_pc_ff;
    ram_we        = 1'b0;
    ram_wa        = m_addr;
    ram_wd        = alu_o.res;
    if (pd_ff) begin
      // Wake pin or interrupt request ends power-down
      if (ctl_s2_ff != 2'h0) nxt_pd = 1'b0;
    end else if (ex_stb && tbl_pend_ff) begin
      // [RL15] table word lands in data registers
      ram_we        = 1'b1;
      ram_wa        = tbl_dst_ff;
      ram_wd        = PROG_DATA[7:0];
      nxt_tblh      = PROG_DATA[15:8];
      nxt_tbl_pend  = 1'b0;
      nxt_prog_addr = ir_pc_ff + 11'h001;
    end else if (ex_stb) begin
      nxt_ir        = PROG_DATA;
      nxt_ir_pc     = prog_addr_ff;
      nxt_ir_valid  = 1'b1;
      nxt_prog_addr = prog_addr_ff + 11'h001;
      if (ir_valid_ff && irq_take) begin
        // [RL17] interrupt pushes only the address
        stk_we        = 1'b1;
        nxt_sp        = sp_ff + SP_ONE;
        nxt_prog_addr = `MCUIT_INT_VECTOR;
        nxt_ir_valid  = 1'b0;
        nxt_ie        = 1'b0;
      end else if (exec_now) begin
        nxt_done = 1'b1;
        // [RL8] accumulator loads
        if (alu_o.wr_acc) nxt_acc = alu_o.res;
        if (alu_o.set_c) nxt_c = alu_o.c;
        if (alu_o.set_z) nxt_z = alu_o.z;
        // [RL5] taken skip squashes the prefetch
        if (alu_o.skip) nxt_ir_valid = 1'b0;
        if (alu_o.wr_mem) begin
          ram_we = 1'b1;
          case (m_addr)
            // [RL4] low byte write redirects
            `MCUIT_ADDR_PCL: begin
              nxt_prog_addr = {ir_pc_ff[10:8], alu_o.res};
              nxt_ir_valid  = 1'b0;
            end
            `MCUIT_ADDR_TBLH:     nxt_tblh = alu_o.res;
            `MCUIT_ADDR_PORT_OUT: nxt_port_out = alu_o.res;
            // A direct write wins over flags from the same op
            `MCUIT_ADDR_STATUS: begin
              nxt_c  = alu_o.res[`MCUIT_STATUS_C];
              nxt_z  = alu_o.res[`MCUIT_STATUS_Z];
              nxt_ie = alu_o.res[`MCUIT_STATUS_IE];
            end
            default: ;
          endcase
        end
        case (op)
          // [RL18] drop prefetch, fetch target
          mcuit_pkg::OP_JUMP: begin
            nxt_prog_addr = target;
            nxt_ir_valid  = 1'b0;
          end
          // [RL7] call pushes return point
          mcuit_pkg::OP_CALL: begin
            stk_we        = 1'b1;
            stk_wd        = ir_pc_ff + 11'h001;
            nxt_sp        = sp_ff + SP_ONE;
            nxt_prog_addr = target;
            nxt_ir_valid  = 1'b0;
          end
          // [RL3] returns pop, two cycles
          mcuit_pkg::OP_RET, mcuit_pkg::OP_INTERRUPT_EXIT: begin
            nxt_sp        = sp_ff - SP_ONE;
            nxt_prog_addr = stk_ff[sp_ff - SP_ONE];
            nxt_ir_valid  = 1'b0;
            if (op == mcuit_pkg::OP_INTERRUPT_EXIT) nxt_ie = 1'b1;
          end
          // Prefetched word is held, not dropped, so the read takes two cycles, one extra
          mcuit_pkg::OP_TABRD: begin
            nxt_tbl_pend  = 1'b1;
            nxt_tbl_dst   = m_addr;
            nxt_prog_addr = {`MCUIT_TBL_PAGE, acc_ff};
          end
          // [RL16] power-down and watchdog
          mcuit_pkg::OP_HALT:   nxt_pd = 1'b1;
          mcuit_pkg::OP_CLRWDT: nxt_wdt = 1'b1;
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      prog_addr_ff <= `MCUIT_RST_PC;
      ir_ff        <= 16'h0000;
      ir_pc_ff     <= `MCUIT_RST_PC;
      ir_valid_ff  <= 1'b0;
      acc_ff       <= 8'h00;
      c_ff         <= 1'b0;
      z_ff         <= 1'b0;
      ie_ff        <= 1'b0;
      tblh_ff      <= 8'h00;
      tbl_pend_ff  <= 1'b0;
      tbl_dst_ff   <= 8'h00;
      sp_ff        <= '0;
      pd_ff        <= 1'b0;
      port_out_ff  <= 8'h00;
      wdt_ff       <= 1'b0;
      done_ff      <= 1'b0;
    end else begin
      prog_addr_ff <= nxt_prog_addr;
      ir_ff        <= nxt_ir;
      ir_pc_ff     <= nxt_ir_pc;
      ir_valid_ff  <= nxt_ir_valid;
      acc_ff       <= nxt_acc;
      c_ff         <= nxt_c;
      z_ff         <= nxt_z;
      ie_ff        <= nxt_ie;
      tblh_ff      <= nxt_tblh;
      tbl_pend_ff  <= nxt_tbl_pend;
      tbl_dst_ff   <= nxt_tbl_dst;
      sp_ff        <= nxt_sp;
      pd_ff        <= nxt_pd;
      port_out_ff  <= nxt_port_out;
      wdt_ff       <= nxt_wdt;
      done_ff      <= nxt_done;
    end
  end

  // Storage arrays carry no reset; contents are undefined until written
  always_ff @(posedge CLK) begin
    if (stk_we) stk_ff[sp_ff] <= stk_wd;
    if (ram_we) ram_ff[ram_wa] <= ram_wd;
  end

  assign PROG_ADDR  = prog_addr_ff;
  assign PORT_OUT   = port_out_ff;
  assign POWER_DOWN = pd_ff;
  assign WDT_CLEAR  = wdt_ff;
  assign EXEC_DONE  = done_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  // [RL1] strobe every four
  AST_CYCLE_FOUR: assert property (ex_stb |=> !ex_stb [*3] ##1 ex_stb) // [RL1]
    else $error("instruction strobe not every four clocks");

  // [RL2] sequential single cycle
  AST_ONE_CYCLE: assert property ( // [RL2]
    exec_now && op == mcuit_pkg::OP_MOV_A_X |=> ir_valid_ff
      && prog_addr_ff == $past(prog_addr_ff) + 11'h001)
    else $error("single cycle op lost its slot");

  // [RL3] two-cycle flow ops
  AST_TWO_CYCLE: assert property ( // [RL3]
    exec_now && op inside {mcuit_pkg::OP_JUMP, mcuit_pkg::OP_CALL,
      mcuit_pkg::OP_RET, mcuit_pkg::OP_INTERRUPT_EXIT} |=> !ir_valid_ff [*4] ##1 ir_valid_ff)
    else $error("flow op did not take exactly two cycles");

  // [RL4] low byte write jumps
  AST_PCL_JUMP: assert property ( // [RL4]
    exec_now && alu_o.wr_mem && m_addr == `MCUIT_ADDR_PCL
      |=> !ir_valid_ff && prog_addr_ff[7:0] == $past(ram_wd))
    else $error("low byte write did not redirect");

  // [RL5] taken skip costs a bubble
  AST_SKIP: assert property ( // [RL5]
    exec_now && alu_o.skip |=> !ir_valid_ff ##4 (ir_valid_ff && !EXEC_DONE))
    else $error("taken skip wrong length");

  // [RL6] untaken skip runs next
  AST_NO_SKIP: assert property ( // [RL6]
    exec_now && op inside {mcuit_pkg::OP_SZ_M, mcuit_pkg::OP_SZ_BIT,
      mcuit_pkg::OP_SNZ_BIT} && !alu_o.skip |=> ir_valid_ff)
    else $error("untaken skip dropped next instruction");

  // [RL7] call return point
  AST_CALL_PUSH: assert property ( // [RL7]
    exec_now && op == mcuit_pkg::OP_CALL |=> stk_ff[$past(sp_ff)] == $past(ir_pc_ff)
      + 11'h001 && prog_addr_ff == $past(target) && acc_ff == $past(acc_ff))
    else $error("call pushed wrong return point");

  // [RL7] jump saves nothing
  AST_JUMP: assert property ( // [RL7]
    exec_now && op == mcuit_pkg::OP_JUMP |=> sp_ff == $past(sp_ff)
      && prog_addr_ff == $past(target))
    else $error("jump touched the stack");

  // [RL9] carry above 255
  AST_ADD_CARRY: assert property ( // [RL9]
    exec_now && op inside {mcuit_pkg::OP_ADD_A_M, mcuit_pkg::OP_ADD_A_X}
      |=> c_ff == ($past(add_sum9) > `MCUIT_BYTE_MAX))
    else $error("add carry wrong");

  // [RL10] increment to accumulator
  AST_INCREMENT_TO_ACC: assert property ( // [RL10]
    exec_now && op == mcuit_pkg::OP_INCREMENT_TO_ACC_M |=> acc_ff == $past(m_rd) + 8'h01)
    else $error("increment to accumulator wrong");

  // [RL11] logic zero flag
  AST_LOGIC_ZERO: assert property ( // [RL11]
    exec_now && op inside {mcuit_pkg::OP_AND_A_M, mcuit_pkg::OP_OR_A_M,
      mcuit_pkg::OP_XOR_A_M} |=> z_ff == (acc_ff == 8'h00))
    else $error("zero flag wrong after logic op");

  // [RL14] only one bit changes
  AST_BIT_SET: assert property ( // [RL14]
    exec_now && op == mcuit_pkg::OP_SET_BIT |-> ram_we
      && (ram_wd ^ m_rd) == ((8'h01 << bit_sel) & ~m_rd))
    else $error("bit set touched other bits");

  // [RL15] table read holds one cycle
  AST_TABLE: assert property ( // [RL15]
    exec_now && op == mcuit_pkg::OP_TABRD |=> tbl_pend_ff [*4] ##1 !tbl_pend_ff)
    else $error("table read wrong length");

  // [RL16] halt powers down
  AST_HALT: assert property ( // [RL16]
    exec_now && op == mcuit_pkg::OP_HALT |=> POWER_DOWN ##1 !EXEC_DONE)
    else $error("halt did not power down");

endmodule : mcuit_core
`default_nettype wire

// ===== bench/mcuit_core_test.sv
`timescale 1ns/10ps
`default_nettype none

module mcuit_core_test;
  logic                   clk;
  logic                   rst;
  mcuit_pkg::mcuit_addr_t prog_addr;
  mcuit_pkg::mcuit_word_t prog_data;
  logic [7:0]             port_in;
  logic [7:0]             port_out;
  logic                   int_req;
  logic                   wake;
  logic                   power_down;
  logic                   wdt_clear;
  logic                   exec_done;
  int                     miscompares = 0;
  int                     samples_checked = 0;
  int                     cyc = 0;
  int                     wdt_at;
  int                     done_t[$];
  logic [7:0]             done_p[$];
  mcuit_pkg::mcuit_word_t rom[2048];
  mcuit_pkg::mcuit_addr_t pc;
  // Executed-order mask of the two-cycle instructions
  localparam logic [29:0] two_cyc = 30'h1069280;

  mcuit_core i_mcuit_core (
    .CLK        (clk),
    .RST        (rst),
    .PROG_ADDR  (prog_addr),
    .PROG_DATA  (prog_data),
    .PORT_IN    (port_in),
    .PORT_OUT   (port_out),
    .INT_REQ    (int_req),
    .WAKE       (wake),
    .POWER_DOWN (power_down),
    .WDT_CLEAR  (wdt_clear),
    .EXEC_DONE  (exec_done)
  );

  // ----------------------------------------------------------------
  // Clock, program memory and monitors
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // One-clock-latency ROM, well inside the allowed fetch window
  always @(posedge clk) begin
    prog_data <= rom[prog_addr];
    cyc <= cyc + 1;
  end

  // Sample mid-cycle so the executing edge has settled
  always @(negedge clk) begin
    if (exec_done === 1'b1) begin
      done_t.push_back(cyc);
      done_p.push_back(port_out);
    end
    if (wdt_clear === 1'b1) wdt_at = done_t.size() - 1;
  end

  task automatic chk_byte(string n, logic [7:0] e, logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk_byte

  task automatic chk_int(string n, int e, int g);
    samples_checked++;
    if (g != e) begin
      miscompares++;
      $display("Error %s expected %0d seen %0d", n, e, g);
    end
  endtask : chk_int

  task automatic finish_test();
    if (miscompares == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  task automatic p(mcuit_pkg::mcuit_op_e o, logic [10:0] f);
    rom[pc] = {o, f};
    pc++;
  endtask : p

  // ----------------------------------------------------------------
  // Program image and checks
  // ----------------------------------------------------------------
  task automatic load(logic [7:0] ra, logic [7:0] rb, logic [15:0] tw);
    foreach (rom[i]) rom[i] = 16'h0000;
    pc = 11'h000;
    p(mcuit_pkg::OP_MOV_A_X, {3'h0, ra});
    p(mcuit_pkg::OP_ADD_A_X, {3'h0, rb});
    p(mcuit_pkg::OP_MOV_M_A, 11'h012);
    p(mcuit_pkg::OP_MOV_A_M, 11'h00A);
    p(mcuit_pkg::OP_MOV_M_A, 11'h012);
    p(mcuit_pkg::OP_MOV_A_X, 11'h000);
    p(mcuit_pkg::OP_MOV_M_A, 11'h020);
    p(mcuit_pkg::OP_SZ_M, 11'h020);
    p(mcuit_pkg::OP_MOV_A_X, 11'h0EE);
    p(mcuit_pkg::OP_SET_BIT, 11'h320);
    p(mcuit_pkg::OP_SNZ_BIT, 11'h320);
    p(mcuit_pkg::OP_MOV_A_X, 11'h0EE);
    p(mcuit_pkg::OP_INCREMENT_TO_ACC_M, 11'h020);
    p(mcuit_pkg::OP_MOV_M_A, 11'h012);
    p(mcuit_pkg::OP_CALL, 11'h040);
    p(mcuit_pkg::OP_MOV_M_A, 11'h012);
    p(mcuit_pkg::OP_JUMP, 11'h050);
    pc = 11'h040;
    p(mcuit_pkg::OP_RLC_M, 11'h020);
    p(mcuit_pkg::OP_MOV_A_M, 11'h020);
    p(mcuit_pkg::OP_RET, 11'h000);
    pc = 11'h050;
    p(mcuit_pkg::OP_TABRD, 11'h021);
    p(mcuit_pkg::OP_MOV_A_M, 11'h021);
    p(mcuit_pkg::OP_MOV_M_A, 11'h012);
    p(mcuit_pkg::OP_MOV_A_M, 11'h008);
    p(mcuit_pkg::OP_MOV_M_A, 11'h012);
    p(mcuit_pkg::OP_MOV_A_X, 11'h058);
    p(mcuit_pkg::OP_MOV_M_A, 11'h006);
    p(mcuit_pkg::OP_MOV_M_A, 11'h012);
    p(mcuit_pkg::OP_CLRWDT, 11'h000);
    p(mcuit_pkg::OP_MOV_M_A, 11'h022);
    p(mcuit_pkg::OP_XOR_A_M, 11'h022);
    p(mcuit_pkg::OP_MOV_A_M, 11'h00A);
    p(mcuit_pkg::OP_MOV_M_A, 11'h012);
    p(mcuit_pkg::OP_HALT, 11'h000);
    // After wake: copy the pins out, enable interrupts, then idle in a loop
    p(mcuit_pkg::OP_MOV_A_M, 11'h013);
    p(mcuit_pkg::OP_MOV_M_A, 11'h012);
    p(mcuit_pkg::OP_MOV_A_X, 11'h004);
    p(mcuit_pkg::OP_MOV_M_A, 11'h00A);
    p(mcuit_pkg::OP_JUMP, 11'h062);
    rom[11'h710] = tw;
    rom[11'h711] = tw;
  endtask : load

  task automatic run(logic [7:0] ra, logic [7:0] rb, logic [15:0] tw);
    logic [8:0] s;
    int         n;
    s = {1'b0, ra} + {1'b0, rb};
    @(posedge clk);
    rst <= 1'b1;
    port_in <= {1'b1, 7'($urandom)}; // Top bit set so it never matches the status byte
    load(ra, rb, tw);
    repeat (2) @(posedge clk);
    chk_byte("port_out_rst", 8'h00, port_out);
    done_t.delete();
    done_p.delete();
    wdt_at = -1;
    rst <= 1'b0;
    n = 0;
    while (done_t.size() < 31 && n < 600) begin
      @(posedge clk);
      n++;
    end
    chk_int("exec_count", 31, done_t.size());
    if (done_t.size() < 31) finish_test();
    for (int k = 0; k < 30; k++)
      chk_int("gap", 4 + 4 * two_cyc[k], done_t[k+1] - done_t[k]);
    chk_byte("sum", s[7:0], done_p[2]);
    chk_byte("flags", {6'h00, s[7:0] == 8'h00, s[8]}, done_p[4] & 8'h03);
    chk_byte("increment_to_acc", 8'h09, done_p[11]);
    chk_byte("rotate", {7'h08, s[8]}, done_p[16]);
    chk_byte("tbl_lo", tw[7:0], done_p[20]);
    chk_byte("tbl_hi", tw[15:8], done_p[22]);
    chk_byte("zero", 8'h02, done_p[29] & 8'h02);
    chk_int("wdt_pos", 25, wdt_at);
    repeat (2) @(posedge clk);
    // Outputs are read mid-cycle, away from the edge that launches them
    @(negedge clk);
    chk_byte("halt", 8'h01, {7'h00, power_down});
    @(posedge clk);
    wake <= 1'b1;
    n = 0;
    while (power_down !== 1'b0 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk_byte("wake", 8'h00, {7'h00, power_down});
    if (power_down !== 1'b0) finish_test();
    @(posedge clk);
    wake <= 1'b0;
    repeat (16) @(posedge clk);
    @(negedge clk);
    chk_byte("pin_in", port_in, port_out);
    // Vector word copies the accumulator out: entry must leave it alone
    @(posedge clk);
    int_req <= 1'b1;
    n = 0;
    while (port_out !== 8'h04 && n < 80) begin
      @(negedge clk);
      n++;
    end
    chk_byte("int_acc", 8'h04, port_out);
    if (port_out !== 8'h04) finish_test();
    @(posedge clk);
    int_req <= 1'b0;
  endtask : run

  // First pass is the wrap-to-zero corner, then random operands
  initial begin
    rst = 1'b1;
    port_in = 8'h00;
    int_req = 1'b0;
    wake = 1'b0;
    prog_data = 16'h0000;
    void'($urandom(90));
    for (int it = 0; it < 3; it++) begin
      if (it == 0) run(8'hFF, 8'h01, 16'(($urandom)));
      else run(8'($urandom), 8'($urandom), 16'($urandom));
    end
    finish_test();
  end
endmodule : mcuit_core_test

`default_nettype wire
